// ==== design/ara_cmp_if.sv ====
// carrier between the register bank and the input limit comparator
`timescale 1ns/10ps
interface ara_cmp_if;
  import ara_pkg::*;
  logic [RES_W-1:0] sample;
  logic sample_valid;
  logic [RES_W-1:0] upper_lim;
  logic [RES_W-1:0] lower_lim;
  logic [HYST_W-1:0] hyst;
  logic live_high;
  logic live_low;
  modport bank (output sample, output sample_valid, output upper_lim, output lower_lim, output hyst,
    input live_high, input live_low);
  modport cmp (input sample, input sample_valid, input upper_lim, input lower_lim, input hyst,
    output live_high, output live_low);
endinterface

// ==== design/ara_limit_cmp.sv ====
// input limit comparator with hysteresis, live high and low flags
`timescale 1ns/10ps
module ara_limit_cmp
  import ara_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  ara_cmp_if.cmp cif
);
  logic [RES_W:0] band;
  logic [RES_W:0] hi_release;
  logic [RES_W:0] lo_release;

  // only the upper six hysteresis bits count, the two low bits are forced to zero
  assign band = {{(RES_W+1-HYST_W){1'b0}}, cif.hyst[HYST_W-1:HYST_ZERO_W], {HYST_ZERO_W{1'b0}}};
  // 17-bit math so the release points cannot wrap past the code range
  assign hi_release = {1'b0, cif.upper_lim} - band;
  assign lo_release = {1'b0, cif.lower_lim} + band;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cif.live_high <= 1'b0;
    end else if (ce && cif.sample_valid) begin
      if (!cif.live_high && cif.sample > cif.upper_lim) begin
        cif.live_high <= 1'b1;
      end else if (cif.live_high && !hi_release[RES_W] && {1'b0, cif.sample} < hi_release) begin
        cif.live_high <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cif.live_low <= 1'b0;
    end else if (ce && cif.sample_valid) begin
      if (!cif.live_low && cif.sample < cif.lower_lim) begin
        cif.live_low <= 1'b1;
      end else if (cif.live_low && {1'b0, cif.sample} > lo_release) begin
        cif.live_low <= 1'b0;
      end
    end
  end
endmodule

// ==== design/ara_pkg.sv ====
// shared constants for the converter range and alarm register bank
package ara_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 16;
  localparam int HYST_W = 8;
  localparam int CODE_W = 4;
  localparam int CLK_HZ = 25000000;
  localparam logic [ADDR_W-1:0] OFF_OUT_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SPAN_CFG = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ALARM = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_UPPER_LIM = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_LOWER_LIM = 8'h28;
  localparam int SPAN_CODE_LSB = 0;
  localparam int VREF_OFF_BIT = 6;
  localparam int APPEND_LSB = 10;
  localparam int APPEND_W = 2;
  localparam int LIM_LSB = 0;
  localparam int HYST_LSB = 24;
  localparam int HYST_ZERO_W = 2;
  localparam int LIVE_SUP_LOW_BIT = 15;
  localparam int LIVE_SUP_HIGH_BIT = 14;
  localparam int LIVE_IN_LOW_BIT = 11;
  localparam int LIVE_IN_HIGH_BIT = 10;
  localparam int TRIP_SUP_LOW_BIT = 7;
  localparam int TRIP_SUP_HIGH_BIT = 6;
  localparam int TRIP_IN_LOW_BIT = 5;
  localparam int TRIP_IN_HIGH_BIT = 4;
  localparam int ANY_TRIP_BIT = 0;
  localparam int APPEND_HIGH_BIT = 0;
  localparam int APPEND_LOW_BIT = 1;
  localparam logic [CODE_W-1:0] SPAN_RST = 4'h0;
  localparam logic [CODE_W-1:0] SPAN_BI_3 = 4'h0;
  localparam logic [CODE_W-1:0] SPAN_BI_2P5 = 4'h1;
  localparam logic [CODE_W-1:0] SPAN_BI_1P5 = 4'h2;
  localparam logic [CODE_W-1:0] SPAN_BI_1P25 = 4'h3;
  localparam logic [CODE_W-1:0] SPAN_BI_0P625 = 4'h4;
  localparam logic [CODE_W-1:0] SPAN_UNI_3 = 4'h8;
  localparam logic [CODE_W-1:0] SPAN_UNI_2P5 = 4'h9;
  localparam logic [CODE_W-1:0] SPAN_UNI_1P5 = 4'ha;
  localparam logic [CODE_W-1:0] SPAN_UNI_1P25 = 4'hb;
  localparam logic [RES_W-1:0] UPPER_LIM_RST = 16'hffff;
  localparam logic [RES_W-1:0] LOWER_LIM_RST = 16'h0000;
  localparam logic [HYST_W-1:0] HYST_RST = 8'h00;
  localparam logic [APPEND_W-1:0] APPEND_RST = 2'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/ara_range_alarm_regs.sv ====
// range configuration and alarm status register bank behind an axi4-lite slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
module ara_range_alarm_regs
  import ara_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [RES_W-1:0] sample_data,
  input wire logic sample_valid,
  input wire logic supply_low_pin,
  input wire logic supply_high_pin,
  output logic [CODE_W-1:0] span_code,
  output logic onchip_vref_off,
  output logic [APPEND_W-1:0] frame_live_flags,
  output logic [APPEND_W-1:0] frame_flags_en
);
  ara_cmp_if cif ();

  logic [ADDR_W-1:0] awaddr_reg;
  logic aw_held_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W/8-1:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [CODE_W-1:0] span_reg;
  logic vref_off_reg;
  logic [APPEND_W-1:0] append_live_input_flags;
  logic [RES_W-1:0] input_upper_limit;
  logic [RES_W-1:0] input_lower_limit;
  logic [HYST_W-1:0] input_limit_hysteresis;
  logic sup_low_meta_reg;
  logic sup_low_reg;
  logic sup_high_meta_reg;
  logic sup_high_reg;
  logic latched_supply_low;
  logic latched_supply_high;
  logic latched_input_low;
  logic latched_input_high;
  logic any_latched_alarm;
  logic [APPEND_W-1:0] frame_live_reg;
  logic wr_go;
  logic rd_go;
  logic alarm_read;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] alarm_word;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [CODE_W-1:0] new_span;
  logic [DATA_W-1:0] span_word;
  logic [DATA_W-1:0] limit_word;
  logic [DATA_W-1:0] lower_word;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] limit_merged;
  logic [DATA_W-1:0] lower_merged;
  logic [DATA_W-1:0] ctrl_merged;

  // merge a write into a stored field, byte lane by byte lane
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
                                              input logic [DATA_W/8-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < DATA_W/8; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic span_valid(input logic [CODE_W-1:0] code);
    case (code)
      SPAN_BI_3, SPAN_BI_2P5, SPAN_BI_1P5, SPAN_BI_1P25, SPAN_BI_0P625: span_valid = 1'b1;
      SPAN_UNI_3, SPAN_UNI_2P5, SPAN_UNI_1P5, SPAN_UNI_1P25: span_valid = 1'b1;
      default: span_valid = 1'b0;
    endcase
  endfunction

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    known_addr = (a == OFF_OUT_CTRL) || (a == OFF_SPAN_CFG) || (a == OFF_ALARM) ||
                 (a == OFF_UPPER_LIM) || (a == OFF_LOWER_LIM);
  endfunction

  // a tripped flag clears on an alarm read, but a live condition in that cycle sets it again
  function automatic logic trip_next(input logic old_f, input logic clr, input logic live);
    trip_next = (old_f && !clr) || live;
  endfunction

  // write and read channel handshakes; both write halves may arrive in either order
  assign s_axi_awready = ce && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = ce && !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign wr_go = ce && aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_hit = known_addr(awaddr_reg);
  assign rd_hit = known_addr(s_axi_araddr);
  assign alarm_read = rd_go && (s_axi_araddr == OFF_ALARM);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= ZERO_WORD;
      wstrb_reg <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // stored fields at their register positions; every other bit stays zero, so reserved bits never store
  always_comb begin
    span_word = ZERO_WORD;
    span_word[SPAN_CODE_LSB +: CODE_W] = span_reg;
    span_word[VREF_OFF_BIT] = vref_off_reg;
    limit_word = ZERO_WORD;
    limit_word[LIM_LSB +: RES_W] = input_upper_limit;
    limit_word[HYST_LSB +: HYST_W] = input_limit_hysteresis;
    lower_word = ZERO_WORD;
    lower_word[LIM_LSB +: RES_W] = input_lower_limit;
    ctrl_word = ZERO_WORD;
    ctrl_word[APPEND_LSB +: APPEND_W] = append_live_input_flags;
  end

  // byte-lane merge done once per register, so each field is a plain slice of a named word
  assign wr_word = merge(span_word, wdata_reg, wstrb_reg);
  assign limit_merged = merge(limit_word, wdata_reg, wstrb_reg);
  assign lower_merged = merge(lower_word, wdata_reg, wstrb_reg);
  assign ctrl_merged = merge(ctrl_word, wdata_reg, wstrb_reg);
  assign new_span = wr_word[SPAN_CODE_LSB +: CODE_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      span_reg <= SPAN_RST;
      vref_off_reg <= 1'b0;
    end else if (ce && wr_go && awaddr_reg == OFF_SPAN_CFG) begin
      vref_off_reg <= wr_word[VREF_OFF_BIT];
      // an unlisted code would leave the front end undefined, so such a write keeps the old span
      if (span_valid(new_span)) begin
        span_reg <= new_span;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_upper_limit <= UPPER_LIM_RST;
      input_limit_hysteresis <= HYST_RST;
      input_lower_limit <= LOWER_LIM_RST;
      append_live_input_flags <= APPEND_RST;
    end else if (ce && wr_go) begin
      if (awaddr_reg == OFF_UPPER_LIM) begin
        input_upper_limit <= limit_merged[LIM_LSB +: RES_W];
        input_limit_hysteresis <= limit_merged[HYST_LSB +: HYST_W];
      end
      if (awaddr_reg == OFF_LOWER_LIM) begin
        input_lower_limit <= lower_merged[LIM_LSB +: RES_W];
      end
      if (awaddr_reg == OFF_OUT_CTRL) begin
        append_live_input_flags <= ctrl_merged[APPEND_LSB +: APPEND_W];
      end
    end
  end

  // comparator inputs come straight from same-clock logic
  assign cif.sample = sample_data;
  assign cif.sample_valid = sample_valid;
  assign cif.upper_lim = input_upper_limit;
  assign cif.lower_lim = input_lower_limit;
  assign cif.hyst = input_limit_hysteresis;

  ara_limit_cmp u_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .cif(cif.cmp)
  );

  // supply comparators are analog and asynchronous, so two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sup_low_meta_reg <= 1'b0;
      sup_low_reg <= 1'b0;
      sup_high_meta_reg <= 1'b0;
      sup_high_reg <= 1'b0;
    end else if (ce) begin
      sup_low_meta_reg <= supply_low_pin;
      sup_low_reg <= sup_low_meta_reg;
      sup_high_meta_reg <= supply_high_pin;
      sup_high_reg <= sup_high_meta_reg;
    end
  end

  // a live alarm present in the clearing read cycle re-sets its flag, so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_supply_low <= 1'b0;
      latched_supply_high <= 1'b0;
      latched_input_low <= 1'b0;
      latched_input_high <= 1'b0;
    end else if (ce) begin
      latched_supply_low <= trip_next(latched_supply_low, alarm_read, sup_low_reg);
      latched_supply_high <= trip_next(latched_supply_high, alarm_read, sup_high_reg);
      latched_input_low <= trip_next(latched_input_low, alarm_read, cif.live_low);
      latched_input_high <= trip_next(latched_input_high, alarm_read, cif.live_high);
    end
  end

  assign any_latched_alarm = latched_supply_low || latched_supply_high ||
                             latched_input_low || latched_input_high;

  always_comb begin
    alarm_word = ZERO_WORD;
    alarm_word[LIVE_SUP_LOW_BIT] = sup_low_reg;
    alarm_word[LIVE_SUP_HIGH_BIT] = sup_high_reg;
    alarm_word[LIVE_IN_LOW_BIT] = cif.live_low;
    alarm_word[LIVE_IN_HIGH_BIT] = cif.live_high;
    alarm_word[TRIP_SUP_LOW_BIT] = latched_supply_low;
    alarm_word[TRIP_SUP_HIGH_BIT] = latched_supply_high;
    alarm_word[TRIP_IN_LOW_BIT] = latched_input_low;
    alarm_word[TRIP_IN_HIGH_BIT] = latched_input_high;
    alarm_word[ANY_TRIP_BIT] = any_latched_alarm;
  end

  always_comb begin
    rd_word = ZERO_WORD;
    case (s_axi_araddr)
      OFF_SPAN_CFG: begin
        rd_word[SPAN_CODE_LSB +: CODE_W] = span_reg;
        rd_word[VREF_OFF_BIT] = vref_off_reg;
      end
      OFF_ALARM: rd_word = alarm_word;
      OFF_UPPER_LIM: begin
        rd_word[LIM_LSB +: RES_W] = input_upper_limit;
        rd_word[HYST_LSB +: HYST_W] = input_limit_hysteresis;
      end
      OFF_LOWER_LIM: rd_word[LIM_LSB +: RES_W] = input_lower_limit;
      OFF_OUT_CTRL: rd_word[APPEND_LSB +: APPEND_W] = append_live_input_flags;
      default: rd_word = ZERO_WORD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= ZERO_WORD;
      rresp_reg <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // frame append flags, registered so the serializer sees a clean level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_live_reg <= '0;
    end else if (ce) begin
      frame_live_reg[APPEND_HIGH_BIT] <= cif.live_high;
      frame_live_reg[APPEND_LOW_BIT] <= cif.live_low;
    end
  end

  assign frame_live_flags = frame_live_reg;
  assign frame_flags_en = append_live_input_flags;
  assign span_code = span_reg;
  assign onchip_vref_off = vref_off_reg;
endmodule

// ==== dv/ara_regs_props.sv ====
// assertion checker for the range and alarm register bank
`timescale 1ns/10ps
module ara_regs_props
  import ara_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CODE_W-1:0] span_code,
  input wire logic onchip_vref_off
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address of the read in flight, so read data can be judged per register
  logic [ADDR_W-1:0] rd_addr_reg;
  logic mapped;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_reg <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end
  assign mapped = rd_addr_reg inside {OFF_OUT_CTRL, OFF_SPAN_CFG, OFF_ALARM, OFF_UPPER_LIM, OFF_LOWER_LIM};
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data dropped early");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_busy_ready: assert property ((!s_axi_bvalid || !s_axi_awready && !s_axi_wready)
    && (!s_axi_rvalid || !s_axi_arready)) else $error("ready while answer pending");
  a_span_legal: assert property (span_code <= SPAN_BI_0P625 || span_code >= SPAN_UNI_3
    && span_code <= SPAN_UNI_1P25) else $error("illegal span code held");
  a_span_read: assert property ($rose(s_axi_rvalid) && rd_addr_reg == OFF_SPAN_CFG
    |-> s_axi_rdata == {25'h0, onchip_vref_off, 2'h0, span_code}) else $error("span readback wrong");
  a_alarm_form: assert property ($rose(s_axi_rvalid) && rd_addr_reg == OFF_ALARM |->
    s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[13:12] == 2'h0 && s_axi_rdata[9:8] == 2'h0
    && s_axi_rdata[3:1] == 3'h0 && s_axi_rdata[0] == |s_axi_rdata[7:4]) else $error("alarm word malformed");
  a_unmapped_err: assert property ($rose(s_axi_rvalid) && !mapped |-> s_axi_rresp == RESP_SLVERR
    && s_axi_rdata == ZERO_WORD) else $error("unmapped read not refused");
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the range and alarm register bank
`timescale 1ns/10ps
module tb;
  import ara_pkg::*;
  logic aclk = '0, aresetn = '0, ce = '1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [DATA_W/8-1:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, onchip_vref_off;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [RES_W-1:0] sample_data = '0;
  logic sample_valid = '0, supply_low_pin = '0, supply_high_pin = '0;
  logic [CODE_W-1:0] span_code;
  logic [APPEND_W-1:0] frame_live_flags, frame_flags_en;
  int num_errors = 0, n_checks = 0;
  logic [31:0] seed = 32'h0000_0025;
  ara_range_alarm_regs u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_data, .sample_valid, .supply_low_pin,
    .supply_high_pin, .span_code, .onchip_vref_off, .frame_live_flags, .frame_flags_en);
  always #20 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // live order {supply low, supply high, input low, input high}, tripped likewise
  function automatic logic [31:0] alm(input logic [3:0] lv, input logic [3:0] tr);
    return {16'h0, lv[3:2], 2'h0, lv[1:0], 2'h0, tr, 3'h0, |tr};
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stuck();
    num_errors++;
    $display("FAIL %0t: bus wait ran out", $time);
    end_of_test();
  endtask
  // ready is sampled at the falling edge, where nothing moves before the next rising edge
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      if (b) chk(s_axi_bresp, er);
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      // late bready makes the response stand for a cycle
      if (i == 2) s_axi_bready <= 1'b1;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 64) stuck();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, b;
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid && s_axi_rready;
      if (b) chk(s_axi_rdata, e);
      if (b) chk(s_axi_rresp, er);
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (i == 1) s_axi_rready <= 1'b1;
      if (b) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 64) stuck();
  endtask
  task automatic smp(input logic [15:0] v);
    sample_data <= v;
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    logic [31:0] d;
    logic [3:0] cur, m;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(OFF_SPAN_CFG, 32'h0, RESP_OKAY);
    rc(OFF_ALARM, 32'h0, RESP_OKAY);
    rc(OFF_UPPER_LIM, 32'h0000_ffff, RESP_OKAY);
    rc(OFF_LOWER_LIM, 32'h0, RESP_OKAY);
    wc(OFF_ALARM, 32'hffff_ffff, RESP_OKAY);
    rc(OFF_ALARM, 32'h0, RESP_OKAY);
    wc(8'h30, rnd(), RESP_SLVERR);
    rc(8'h30, 32'h0, RESP_SLVERR);
    cur = SPAN_RST;
    for (int k = 0; k < 16; k++) begin
      d = rnd();
      d[3:0] = k[3:0];
      if (k < 5 || k >= 8 && k < 12) cur = k[3:0];
      wc(OFF_SPAN_CFG, d, RESP_OKAY);
      chk({span_code, onchip_vref_off}, {cur, d[6]});
      rc(OFF_SPAN_CFG, {25'h0, d[6], 2'h0, cur}, RESP_OKAY);
    end
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      d[11:10] = k[1:0];
      wc(OFF_OUT_CTRL, d, RESP_OKAY);
      chk(frame_flags_en, k[1:0]);
    end
    d = rnd() & 32'hfc00_ffff;
    wc(OFF_UPPER_LIM, d, RESP_OKAY);
    rc(OFF_UPPER_LIM, d, RESP_OKAY);
    d = rnd();
    wc(OFF_LOWER_LIM, d, RESP_OKAY);
    rc(OFF_LOWER_LIM, {16'h0, d[15:0]}, RESP_OKAY);
    wc(OFF_UPPER_LIM, 32'h0000_8000, RESP_OKAY);
    wc(OFF_LOWER_LIM, 32'h0000_1000, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      m = 4'h8 >> k;
      supply_low_pin <= m[3];
      supply_high_pin <= m[2];
      if (k == 2) smp(16'h0800);
      if (k == 3) smp(16'h9000);
      repeat (6) @(posedge aclk);
      chk(frame_live_flags, m[1:0]);
      rc(OFF_ALARM, alm(m, m), RESP_OKAY);
      supply_low_pin <= 1'b0;
      supply_high_pin <= 1'b0;
      smp(16'h4000);
      repeat (2) @(posedge aclk);
      rc(OFF_ALARM, alm(4'h0, m), RESP_OKAY);
      rc(OFF_ALARM, 32'h0, RESP_OKAY);
    end
    wc(OFF_UPPER_LIM, 32'h4000_8000, RESP_OKAY);
    smp(16'h9000);
    chk(frame_live_flags, 2'h1);
    smp(16'h7fe0);
    chk(frame_live_flags, 2'h1);
    smp(16'h7f00);
    chk(frame_live_flags, 2'h0);
    // clock enable low: no handshake offered and a supply pulse never reaches the flags
    ce <= 1'b0;
    supply_high_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h0);
    supply_high_pin <= 1'b0;
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    rc(OFF_ALARM, alm(4'h0, 4'h1), RESP_OKAY);
    // mid-run reset must bring written state back to reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({span_code, onchip_vref_off, frame_live_flags, frame_flags_en}, 9'h000);
    rc(OFF_ALARM, 32'h0, RESP_OKAY);
    rc(OFF_UPPER_LIM, 32'h0000_ffff, RESP_OKAY);
    end_of_test();
  end
endmodule
bind ara_range_alarm_regs ara_regs_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .span_code, .onchip_vref_off);
